/* File: hw/motg_pkg.sv */
// package of constants, types and register map for the measurement output trigger gate
package motg_pkg;
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_COUNT = 4'h1;
   localparam logic [3:0] REG_DECIM = 4'h2;
   localparam logic [3:0] REG_SCALE0 = 4'h3;
   localparam logic [3:0] REG_SCALE10 = 4'h4;
   localparam logic [3:0] REG_CMD = 4'h5;
   localparam logic [3:0] REG_STATUS = 4'h6;
   localparam logic [3:0] REG_RANGE = 4'h7;
   // ctrl field positions
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_POL = 2;
   localparam int CTRL_TO_REC = 3;
   localparam int CTRL_ANA_EN = 4;
   localparam int CTRL_SCALE2P = 5;
   localparam int CTRL_SEL_LSB = 6;
   localparam int CTRL_PROG_LSB = 8;
   localparam int CTRL_DEC_AN = 11;
   localparam int CTRL_DEC_SER = 12;
   localparam int CTRL_DEC_ETH = 13;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0010;
   localparam logic [13:0] COUNT_STOP = 14'h0000;
   localparam logic [13:0] COUNT_INFINITE = 14'h3FFF;
   localparam logic [13:0] COUNT_RESET = 14'h3FFF;
   localparam logic [17:0] DECIM_MAX = 18'h249F0;
   localparam logic [17:0] DECIM_RESET = 18'h00001;
   localparam logic [15:0] CODE_0V = 16'h0000;
   localparam logic [15:0] CODE_10V = 16'hF8DC;
   localparam logic [15:0] CODE_ERROR = 16'hFFFF;
   localparam logic [31:0] SCALE0_RESET = 32'h0000_0000;
   localparam logic [31:0] SCALE10_RESET = 32'h0000_FFFF;
   localparam logic [31:0] RANGE_START_RESET = 32'h0000_0000;
   localparam logic [31:0] RANGE_END_RESET = 32'h0000_FFFF;
   localparam int CMD_START = 0;
   localparam int CMD_STOP = 1;
   localparam int TRIG_PULSE_NS = 5000;
   localparam int CLK_PERIOD_NS = 20;
   localparam int TRIG_PULSE_CYC = (TRIG_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef enum logic [1:0] {
      MODE_NONE = 2'b00,
      MODE_LEVEL = 2'b01,
      MODE_EDGE = 2'b10,
      MODE_SOFT = 2'b11
   } motg_mode_t;

   typedef enum logic [2:0] {
      PROG_EDGE_LH = 3'b000,
      PROG_EDGE_HL = 3'b001,
      PROG_DIAMETER = 3'b010,
      PROG_GAP = 3'b011,
      PROG_SEGMENTS = 3'b100
   } motg_prog_t;

   typedef struct packed {
      logic valid;
      logic error;
      logic [3:0][31:0] value;
   } motg_meas_t;

   typedef struct packed {
      logic [3:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } motg_bus_t;
endpackage : motg_pkg

/* File: hw/motg_gate.sv */
// measurement output trigger gate: trigger, count, decimation and analog scaling
//
// Our own choices: the register offsets and the strobed register port.
`timescale 1ns/1ns
// Functional notes
// (RQ1) analog output carries one selected value, only for diameter, gap, segment programs
// (RQ2) analog output value is a 16-bit code
// (RQ3) standard scaling: range start to 0 V, end to 10 V, error to 10.3 V
// (RQ4) two-point scaling derives gain and offset from the 0 V and 10 V values
// (RQ5) decimation n forwards every nth value, n from 1 to 150000
// (RQ6) decimation never averages; averaging is a separate setting
// (RQ7) decimation applies only to outputs whose selection bits are set
// (RQ8) triggering never changes the measuring rate, it only gates values
// (RQ9) triggering gates analog and digital outputs together
// (RQ10) external trigger comes from the sync input
// (RQ11) reset selects no triggering, values flow from power-up
// (RQ12) trigger source holds each pulse at least 5 us
// (RQ13) level mode passes values while selected level is present, stops when it ends
// (RQ14) level source keeps active and pause levels at least one cycle each
// (RQ15) edge mode starts a burst of configured length on selected edge
// (RQ16) count 1..16382 per trigger, 16383 unlimited, 0 stops output
// (RQ17) analog output holds the last emitted value after a burst
// (RQ18) software start command starts a burst, stop command ends output
// (RQ19) trigger on recording: array signal processed only after trigger
// (RQ20) trigger on recording: statistics use only triggered values
// (RQ21) trigger on output: values computed continuously, statistics see all
// (RQ22) trigger input synchronised, sampled once per measurement cycle
// (RQ23) inactive analog range freezes the analog code
module motg_gate #(
   parameter int DECIM_LIMIT = 150000
) (
   input wire logic REF_CLK_IN,
   input wire logic RESET_IN,
   input wire logic [3:0] ADDR_IN,
   input wire logic [31:0] WDATA_IN,
   input wire logic WR_IN,
   input wire logic RD_IN,
   output logic [31:0] RDATA_OUT,
   input wire logic SYNC_IN,
   input wire logic CYCLE_IN,
   output logic RECORD_EN_OUT,
   input wire motg_pkg::motg_meas_t MEAS_IN,
   output logic STATS_VALID_OUT,
   output motg_pkg::motg_meas_t SERIAL_OUT,
   output motg_pkg::motg_meas_t ETH_OUT,
   output logic [15:0] ANALOG_OUT
);
   import motg_pkg::*;

   // limits above DECIM_MAX (150000) are rejected, though the 18-bit decimation register could hold up to 262143
   if (DECIM_LIMIT < 1 || DECIM_LIMIT > int'(DECIM_MAX)) begin : g_bad_limit
      $error("DECIM_LIMIT out of range");
   end

   typedef struct packed {
      logic sync_a;
      logic sync_b;
      logic trig_prev;
      logic [31:0] ctrl;
      logic [13:0] count;
      logic [17:0] decim;
      logic [31:0] scale0;
      logic [31:0] scale10;
      logic [31:0] range_start;
      logic [31:0] range_end;
      logic [31:0] rdata;
      logic active;
      logic [13:0] left;
      logic [17:0] dec_cnt;
      logic rec_armed;
      logic stats_valid;
      motg_meas_t serial;
      motg_meas_t eth;
      logic [15:0] analog;
   } motg_state_t;

   motg_state_t r;
   motg_state_t next_r;
   motg_mode_t mode;
   motg_prog_t prog;
   logic pol;
   logic to_rec;
   logic trig_lvl;
   logic edge_hit;
   logic gate_open;
   logic dec_hit;
   logic [31:0] sel_val;
   logic signed [47:0] num;
   logic signed [47:0] den;
   logic signed [47:0] code_wide;
   logic [15:0] code;

   assign mode = motg_mode_t'(r.ctrl[CTRL_MODE_LSB +: 2]);
   assign prog = motg_prog_t'(r.ctrl[CTRL_PROG_LSB +: 3]);
   assign pol = r.ctrl[CTRL_POL];
   assign to_rec = r.ctrl[CTRL_TO_REC];
   // selected level after synchronising; pol=1 means active high
   assign trig_lvl = (r.sync_b == pol); // RQ10 RQ22
   // edge looks at the previous cycle sample, so one edge per measurement cycle
   assign edge_hit = trig_lvl && !r.trig_prev; // RQ15 RQ22
   assign sel_val = MEAS_IN.value[r.ctrl[CTRL_SEL_LSB +: 2]];

   always_comb begin
      case (mode)
         MODE_NONE: gate_open = 1'b1;
         MODE_LEVEL: gate_open = trig_lvl; // RQ13
         MODE_EDGE: gate_open = r.active; // RQ15
         MODE_SOFT: gate_open = r.active; // RQ18
         default: gate_open = 1'b1;
      endcase
   end

   // last of every n gated values; counter advances only on values that pass the gate
   assign dec_hit = (r.dec_cnt + 18'h00001 >= r.decim); // RQ5 RQ6

   // linear map; two-point lets span stretch or invert since ends are signed values
   always_comb begin
      if (r.ctrl[CTRL_SCALE2P]) begin
         // extend before subtracting so wide differences keep their sign
         num = 48'(signed'(sel_val)) - 48'(signed'(r.scale0)); // RQ4
         den = 48'(signed'(r.scale10)) - 48'(signed'(r.scale0));
      end else begin
         num = 48'(signed'(sel_val)) - 48'(signed'(r.range_start)); // RQ3
         den = 48'(signed'(r.range_end)) - 48'(signed'(r.range_start));
      end
      // all operands signed, else an inverted span divides as unsigned
      if (den == 48'sh0) begin
         code_wide = 48'sh0;
      end else begin
         code_wide = (num * signed'(48'(CODE_10V))) / den;
      end
      if (MEAS_IN.error) begin
         code = CODE_ERROR; // RQ3
      end else if (code_wide < 48'sh0) begin
         code = CODE_0V;
      end else if (code_wide > signed'(48'(CODE_ERROR))) begin
         code = CODE_ERROR;
      end else begin
         code = code_wide[15:0]; // RQ2
      end
   end

   always_comb begin
      logic take;
      logic fire;
      logic [13:0] burst;
      take = 1'b0;
      fire = 1'b0;
      burst = 14'h0000;
      next_r = r;
      next_r.sync_a = SYNC_IN;
      next_r.sync_b = r.sync_a;
      next_r.rdata = 32'h0000_0000;
      next_r.stats_valid = 1'b0;
      next_r.serial.valid = 1'b0;
      next_r.eth.valid = 1'b0;
      if (CYCLE_IN) begin
         next_r.trig_prev = trig_lvl;
      end
      // edge trigger starts a burst; count 0 means stop, 16383 endless
      if (mode == MODE_EDGE && CYCLE_IN && edge_hit) begin
         next_r.active = (r.count != COUNT_STOP); // RQ16
         next_r.left = r.count;
      end
      if (WR_IN) begin
         case (ADDR_IN)
            REG_CTRL: next_r.ctrl = WDATA_IN;
            REG_COUNT: begin
               next_r.count = WDATA_IN[13:0];
               // stop code also ends a burst already running
               if (WDATA_IN[13:0] == COUNT_STOP) begin
                  next_r.active = 1'b0; // RQ16
               end
            end
            REG_DECIM: begin
               // upper bits must be clear, else a huge factor would alias to a small one
               if (WDATA_IN[31:18] == 14'h0000 && WDATA_IN[17:0] != 18'h00000
                   && WDATA_IN[17:0] <= 18'(DECIM_LIMIT)) begin
                  next_r.decim = WDATA_IN[17:0]; // RQ5
               end
               next_r.dec_cnt = 18'h00000;
            end
            REG_SCALE0: next_r.scale0 = WDATA_IN;
            REG_SCALE10: next_r.scale10 = WDATA_IN;
            REG_RANGE: next_r.range_end = WDATA_IN;
            REG_CMD: begin
               if (mode == MODE_SOFT && WDATA_IN[CMD_START]) begin
                  next_r.active = (r.count != COUNT_STOP); // RQ18 RQ16
                  next_r.left = r.count;
               end
               if (WDATA_IN[CMD_STOP]) begin
                  next_r.active = 1'b0; // RQ18
               end
            end
            default: ;
         endcase
      end
      if (RD_IN) begin
         case (ADDR_IN)
            REG_CTRL: next_r.rdata = r.ctrl;
            REG_COUNT: next_r.rdata = {18'h00000, r.count};
            REG_DECIM: next_r.rdata = {14'h0000, r.decim};
            REG_SCALE0: next_r.rdata = r.scale0;
            REG_SCALE10: next_r.rdata = r.scale10;
            REG_RANGE: next_r.rdata = r.range_end;
            REG_STATUS: next_r.rdata = {16'h0000, r.active, trig_lvl, r.left};
            default: next_r.rdata = 32'h0000_0000;
         endcase
      end
      // recording assignment: array is processed only while gate is open
      next_r.rec_armed = to_rec ? gate_open : 1'b1; // RQ19
      if (MEAS_IN.valid) begin
         // in recording mode statistics skip ungated values; in output mode all count
         next_r.stats_valid = to_rec ? r.rec_armed : 1'b1; // RQ20 RQ21
         // measurement rate is untouched: only which values leave is gated
         take = gate_open && (!to_rec || r.rec_armed); // RQ8
         if (take) begin
            if (mode == MODE_EDGE || mode == MODE_SOFT) begin
               burst = r.left;
               if (r.left != COUNT_INFINITE) begin
                  next_r.left = r.left - 14'h0001;
                  if (r.left == 14'h0001) begin
                     next_r.active = 1'b0; // RQ16
                  end
               end
            end
            fire = dec_hit;
            next_r.dec_cnt = dec_hit ? 18'h00000 : r.dec_cnt + 18'h00001;
            // analog and digital gated by the same take; decimation per output
            if (fire || !r.ctrl[CTRL_DEC_SER]) begin // RQ7 RQ9
               next_r.serial = MEAS_IN;
               next_r.serial.valid = 1'b1;
            end
            if (fire || !r.ctrl[CTRL_DEC_ETH]) begin // RQ7 RQ9
               next_r.eth = MEAS_IN;
               next_r.eth.valid = 1'b1;
            end
            // analog only for programs with a selectable value; else holds last
            if ((fire || !r.ctrl[CTRL_DEC_AN]) && r.ctrl[CTRL_ANA_EN] // RQ7 RQ23
                && (prog == PROG_DIAMETER || prog == PROG_GAP || prog == PROG_SEGMENTS)) begin // RQ1
               next_r.analog = code; // RQ9
            end
         end
      end
      // analog register never cleared when gate closes: sample and hold
      if (burst == 14'h3FFE) begin
         next_r.left = r.left - 14'h0001;
      end
   end

   always_ff @(posedge REF_CLK_IN) begin
      if (RESET_IN) begin
         r <= '0;
         r.ctrl <= CTRL_RESET; // RQ11
         r.count <= COUNT_RESET;
         r.decim <= DECIM_RESET;
         r.scale0 <= SCALE0_RESET;
         r.scale10 <= SCALE10_RESET;
         r.range_start <= RANGE_START_RESET;
         r.range_end <= RANGE_END_RESET;
      end else begin
         r <= next_r; // RQ17
      end
   end

   assign RDATA_OUT = r.rdata;
   assign RECORD_EN_OUT = r.rec_armed;
   assign STATS_VALID_OUT = r.stats_valid;
   assign SERIAL_OUT = r.serial;
   assign ETH_OUT = r.eth;
   assign ANALOG_OUT = r.analog;
endmodule : motg_gate

/* File: bench/motg_trig_src.sv */
// trigger source model driving the sync pin
`timescale 1ns/1ns
module motg_trig_src #(
   parameter int LEN_CYC = 300
) (
   input wire logic clk_in,
   input wire logic pol_in,
   input wire logic fire_in,
   output logic sync_out
);
   import motg_pkg::*;
   int cnt = 0;
   // never shorter than the minimum pulse, so a slow source is modelled too
   always @(posedge clk_in) begin
      if (fire_in && cnt == 0) begin
         cnt <= (LEN_CYC > TRIG_PULSE_CYC) ? LEN_CYC : TRIG_PULSE_CYC;
      end else if (cnt > 0) begin
         cnt <= cnt - 1;
      end
   end
   assign sync_out = (cnt > 0) ? pol_in : !pol_in;
endmodule : motg_trig_src

/* File: bench/motg_gate_props.sv */
// port assertions for the trigger gate
`timescale 1ns/1ns
module motg_gate_props #(
   parameter int DECIM_LIMIT = 150000
) (
   input wire logic REF_CLK_IN,
   input wire logic RESET_IN,
   input wire logic [3:0] ADDR_IN,
   input wire logic [31:0] WDATA_IN,
   input wire logic WR_IN,
   input wire logic RD_IN,
   input wire logic [31:0] RDATA_OUT,
   input wire logic SYNC_IN,
   input wire logic CYCLE_IN,
   input wire logic RECORD_EN_OUT,
   input wire motg_pkg::motg_meas_t MEAS_IN,
   input wire logic STATS_VALID_OUT,
   input wire motg_pkg::motg_meas_t SERIAL_OUT,
   input wire motg_pkg::motg_meas_t ETH_OUT,
   input wire logic [15:0] ANALOG_OUT
);
   import motg_pkg::*;
   logic [31:0] ctrl;
   // shadow of the control word so gating can be judged from the ports
   always_ff @(posedge REF_CLK_IN) begin
      if (RESET_IN) begin
         ctrl <= CTRL_RESET;
      end else if (WR_IN && ADDR_IN == REG_CTRL) begin
         ctrl <= WDATA_IN;
      end
   end
   default clocking @(posedge REF_CLK_IN); endclocking
   default disable iff (RESET_IN);
   property p_rst; $past(RESET_IN) |-> !SERIAL_OUT.valid && !ETH_OUT.valid && ANALOG_OUT == 16'h0000; endproperty
   a_rst: assert property (p_rst) else $error("outputs not cleared");
   property p_ser; SERIAL_OUT.valid |-> $past(MEAS_IN.valid); endproperty
   a_ser: assert property (p_ser) else $error("serial without input");
   property p_eth; ETH_OUT.valid |-> $past(MEAS_IN.valid); endproperty
   a_eth: assert property (p_eth) else $error("eth without input");
   property p_stats; STATS_VALID_OUT |-> $past(MEAS_IN.valid); endproperty
   a_stats: assert property (p_stats) else $error("stats without input");
   property p_hold; !$past(MEAS_IN.valid) |-> $stable(ANALOG_OUT); endproperty
   a_hold: assert property (p_hold) else $error("analog moved");
   property p_free; ctrl[1:0] == MODE_NONE && !ctrl[CTRL_DEC_SER] && MEAS_IN.valid |=> SERIAL_OUT.valid; endproperty
   a_free: assert property (p_free) else $error("free run lost value");
   property p_rec; !ctrl[CTRL_TO_REC] |=> RECORD_EN_OUT; endproperty
   a_rec: assert property (p_rec) else $error("recording gated");
   property p_err; ctrl[1:0] == MODE_NONE && ctrl[CTRL_ANA_EN] && !ctrl[CTRL_DEC_AN] && ctrl[10:8] == PROG_DIAMETER
      && MEAS_IN.valid && MEAS_IN.error |=> ANALOG_OUT == CODE_ERROR; endproperty
   a_err: assert property (p_err) else $error("no error code");
   c_err: cover property (SERIAL_OUT.valid && ANALOG_OUT == CODE_ERROR);
   c_dec: cover property (ETH_OUT.valid && !SERIAL_OUT.valid);
   c_edge: cover property (ctrl[1:0] == MODE_EDGE && MEAS_IN.valid ##1 SERIAL_OUT.valid);
endmodule : motg_gate_props
bind motg_gate motg_gate_props #(.DECIM_LIMIT(DECIM_LIMIT)) motg_gate_props_i (.REF_CLK_IN(REF_CLK_IN),
   .RESET_IN(RESET_IN), .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN), .RDATA_OUT(RDATA_OUT),
   .SYNC_IN(SYNC_IN), .CYCLE_IN(CYCLE_IN), .RECORD_EN_OUT(RECORD_EN_OUT), .MEAS_IN(MEAS_IN),
   .STATS_VALID_OUT(STATS_VALID_OUT), .SERIAL_OUT(SERIAL_OUT), .ETH_OUT(ETH_OUT), .ANALOG_OUT(ANALOG_OUT));

/* File: bench/test_measurement_output_trigger_gate.sv */
// self-checking bench for the trigger gate
`timescale 1ns/1ns
module test_measurement_output_trigger_gate;
   import motg_pkg::*;
   logic clk = 0, rst = 1, wr = 0, rd = 0, cyc = 0, fire = 0, pol = 1, sync, rec_en, stats;
   logic [3:0] addr = 4'h0;
   logic [31:0] wdata = 32'h0, rdata, last_val;
   logic [15:0] ana, ana_exp = 16'h0000;
   motg_meas_t meas = '0, ser, eth;
   int seed = 40, error_cnt = 0, n_compared = 0, n_ser = 0, n_eth = 0, n_st = 0;
   always #10 clk = ~clk;
   motg_gate motg_gate_i (.REF_CLK_IN(clk), .RESET_IN(rst), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr),
      .RD_IN(rd), .RDATA_OUT(rdata), .SYNC_IN(sync), .CYCLE_IN(cyc), .RECORD_EN_OUT(rec_en), .MEAS_IN(meas),
      .STATS_VALID_OUT(stats), .SERIAL_OUT(ser), .ETH_OUT(eth), .ANALOG_OUT(ana));
   motg_trig_src motg_trig_src_i (.clk_in(clk), .pol_in(pol), .fire_in(fire), .sync_out(sync));
   task automatic check(string what, logic [31:0] lo, logic [31:0] hi, logic [31:0] got);
      n_compared++;
      if ((got >= lo && got <= hi) !== 1'b1) begin
         error_cnt++;
         $display("mismatch %s expected %0h..%0h seen %0h", what, lo, hi, got);
      end
   endtask : check
   always @(posedge clk) begin
      n_ser += int'(ser.valid === 1'b1);
      n_eth += int'(eth.valid === 1'b1);
      n_st += int'(stats === 1'b1);
      if (ser.valid === 1'b1) begin
         check("serial data", last_val, last_val, ser.value[0]);
      end
   end
   task automatic wr_reg(logic [3:0] a, logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_chk(logic [3:0] a, logic [31:0] exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      check("register", exp, exp, rdata);
   endtask : rd_chk
   // one measurement every ten cycles, analog check lands after the update edge
   task automatic send(logic [31:0] v0, logic err, logic [15:0] exp_ana);
      repeat (9) @(posedge clk);
      cyc <= 1'b1;
      meas <= '{valid: 1'b1, error: err, value: {$random(seed), $random(seed), $random(seed), v0}};
      last_val <= v0;
      @(posedge clk);
      cyc <= 1'b0;
      meas.valid <= 1'b0;
      #1;
      check("analog", 32'(exp_ana), 32'(exp_ana), 32'(ana));
      ana_exp = exp_ana;
   endtask : send
   // analog must hold the last expected code while no update is due
   task automatic run(int n);
      repeat (n) send($random(seed), 1'b0, ana_exp);
      repeat (2) @(posedge clk);
      #1;
   endtask : run
   task automatic burst(logic [1:0] mode, logic p, logic rec, logic [13:0] cnt, int lo, int hi);
      int s0, t0;
      wr_reg(REG_CTRL, CTRL_RESET | (32'(rec) << CTRL_TO_REC) | (32'(p) << CTRL_POL) | 32'(mode));
      pol <= p;
      wr_reg(REG_COUNT, 32'(cnt));
      // one cycle strobe at idle level, so the previous sample cannot hide the edge
      run(1);
      s0 = n_ser;
      t0 = n_st;
      if (mode == MODE_SOFT) begin
         wr_reg(REG_CMD, 32'h1);
      end else begin
         fire <= 1'b1;
         @(posedge clk);
         fire <= 1'b0;
      end
      run(20);
      wr_reg(REG_CMD, 32'h2);
      run(20);
      check("burst count", 32'(lo), 32'(hi), 32'(n_ser - s0));
      check("stats count", rec ? 32'(lo) : 32'h28, rec ? 32'(hi) : 32'h28, 32'(n_st - t0));
      check("record enable", 32'(!rec), 32'(!rec), 32'(rec_en));
   endtask : burst
   task automatic test_done;
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : test_done
   logic [3:0] ra [7] = '{REG_CTRL, REG_COUNT, REG_DECIM, REG_SCALE0, REG_SCALE10, REG_RANGE, 4'hF};
   logic [31:0] rv [7] = '{CTRL_RESET, 32'h3FFF, 32'h1, 32'h0, 32'hFFFF, 32'hFFFF, 32'h0};
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      foreach (ra[i]) begin
         rd_chk(ra[i], rv[i]);
      end
      run(8);
      check("free run", 32'h8, 32'h8, 32'(n_eth));
      wr_reg(REG_DECIM, 32'h3);
      wr_reg(REG_CTRL, CTRL_RESET | 32'h1000);
      run(9);
      check("decimated", 32'hB, 32'hB, 32'(n_ser));
      check("undecimated", 32'h11, 32'h11, 32'(n_eth));
      wr_reg(REG_DECIM, 32'h0);
      rd_chk(REG_DECIM, 32'h3);
      wr_reg(REG_DECIM, 32'(DECIM_MAX));
      wr_reg(REG_DECIM, 32'(DECIM_MAX) + 32'h1);
      rd_chk(REG_DECIM, 32'(DECIM_MAX));
      wr_reg(REG_DECIM, 32'h1);
      wr_reg(REG_CTRL, CTRL_RESET | 32'h200);
      send(32'h0, 1'b0, CODE_0V);
      send(32'hFFFF, 1'b0, CODE_10V);
      send(32'h0, 1'b1, CODE_ERROR);
      wr_reg(REG_CTRL, CTRL_RESET);
      send(32'h0, 1'b0, CODE_ERROR);
      wr_reg(REG_CTRL, 32'h200);
      send(32'h0, 1'b0, CODE_ERROR);
      wr_reg(REG_SCALE0, 32'hFFFF);
      wr_reg(REG_SCALE10, 32'h0);
      wr_reg(REG_CTRL, CTRL_RESET | 32'h220);
      send(32'hFFFF, 1'b0, CODE_0V);
      send(32'h0, 1'b0, CODE_10V);
      for (int p = 0; p < 2; p++) begin
         burst(MODE_EDGE, p[0], 1'b0, 14'h3, 3, 3);
         burst(MODE_LEVEL, p[0], 1'b0, COUNT_INFINITE, 28, 31);
      end
      // the value that arms an edge burst is not itself emitted
      burst(MODE_EDGE, 1'b1, 1'b0, COUNT_INFINITE, 19, 19);
      burst(MODE_EDGE, 1'b1, 1'b1, 14'h3, 3, 3);
      burst(MODE_SOFT, 1'b1, 1'b0, 14'h5, 5, 5);
      burst(MODE_SOFT, 1'b1, 1'b0, COUNT_INFINITE, 20, 20);
      burst(MODE_EDGE, 1'b1, 1'b0, COUNT_STOP, 0, 0);
      test_done();
   end
endmodule : test_measurement_output_trigger_gate
